// ---- inc/mid_pkg.sv ----
// Purpose: Shared constants and types for the instruction decoder
// Assumes: Opcode layout is local to this core; fetch presents byte 0 in bits 7:0
// Notes: Operation index lives in opcode bits 7:2

package mid_pkg;

	localparam int INSTR_W = 32;
	localparam int REG_SEL_W = 4;
	localparam int IMM_W = 16;
	localparam int LEN_W = 3;

	// Opcode byte fields
	localparam int OPC_LONG_BIT = 0;
	localparam int OPC_VAR_BIT = 1;
	localparam int OPC_OP_LSB = 2;
	localparam int OPC_OP_MSB = 7;
	localparam int OPC_OP_W = OPC_OP_MSB - OPC_OP_LSB + 1;

	// Operand fields
	localparam int REGB_LSB = 8;
	localparam int REGA_LSB = 12;
	localparam int SHORT_IMM_LSB = 8;
	localparam int SHORT_IMM_W = 8;
	localparam int LONG_IMM_LSB = 16;

	localparam logic [LEN_W-1:0] BYTES_SHORT = 3'h2;
	localparam logic [LEN_W-1:0] BYTES_LONG = 3'h4;
	localparam logic [1:0] STEP_ONE = 2'h1;
	localparam logic [1:0] STEP_TWO = 2'h2;

	// Reset sequence: 1024 half clock periods
	localparam int RST_SEQ_HALF_CLOCK_PERIODS = 1024;
	localparam int RST_SEQ_CYCLES = RST_SEQ_HALF_CLOCK_PERIODS / 2;
	localparam int RST_CNT_W = 10;
	localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(RST_SEQ_CYCLES - 1);

	// Enum order is the opcode index
	typedef enum logic [OPC_OP_W-1:0] {
		OP_NULL, OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_CARRY,
		OP_MULTIPLY, OP_DIVIDE, OP_LONG_DIVIDE, OP_COMPLEMENT, OP_NEGATE,
		OP_AND, OP_OR, OP_XOR, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_MOVE,
		OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_COMPARE, OP_MASKED_BYTE_FIELD,
		OP_COMPARE, OP_COMPARE_DECREMENT, OP_COMPARE_INCREMENT, OP_NORMALIZE_COUNT,
		OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
		OP_ARITH_SHIFT_RIGHT, OP_MOVE, OP_BYTE_SIGN_EXTEND_MOVE,
		OP_BYTE_ZERO_EXTEND_MOVE, OP_JUMP, OP_BRANCH_ON_BIT, OP_BRANCH_AND_CLEAR_BIT,
		OP_BRANCH_AND_SET_BIT, OP_CALL, OP_PUSH_AND_CALL, OP_TRAP, OP_PUSH, OP_POP,
		OP_CONTEXT_SWITCH, OP_RETURN, OP_INTER_SEGMENT_RETURN, OP_RETURN_AND_POP,
		OP_INTERRUPT_RETURN, OP_SOFTWARE_RESET, OP_IDLE, OP_POWER_DOWN,
		OP_WATCHDOG_SERVICE, OP_WATCHDOG_DISABLE, OP_END_OF_INIT, OP_ATOMIC,
		OP_EXTENDED_REGISTER, OP_EXTENDED_PAGE, OP_EXTENDED_SEGMENT
	} mid_op_t;

	localparam logic [OPC_OP_W-1:0] OP_LAST_CODE = OP_EXTENDED_SEGMENT;

	typedef enum logic [3:0] {
		ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CMP,
		ALU_COMPLEMENT, ALU_NEGATE, ALU_MOVE
	} mid_alu_t;

	typedef enum logic [1:0] {MD_NONE, MD_MUL, MD_DIV_LOW, MD_DIV_PAIR} mid_md_t;

	typedef enum logic [3:0] {
		BIT_NONE, BIT_CLEAR, BIT_SET, BIT_MOVE, BIT_AND, BIT_OR, BIT_XOR,
		BIT_COMPARE, BIT_FIELD_LOW, BIT_FIELD_HIGH
	} mid_bit_t;

	typedef enum logic [2:0] {SH_NONE, SH_LEFT, SH_RIGHT, SH_ROL, SH_ROR, SH_ARITH_SHIFT_RIGHT_OP} mid_sh_t;

	typedef enum logic [3:0] {
		BR_NONE, BR_JUMP, BR_IF_SET, BR_IF_CLEAR, BR_SET_THEN_CLEAR, BR_CLEAR_THEN_SET,
		BR_CALL, BR_TRAP, BR_RET, BR_RET_SEG, BR_RET_INT
	} mid_br_t;

	typedef enum logic [2:0] {PFX_NONE, PFX_ATOMIC, PFX_REG, PFX_PAGE, PFX_SEGMENT} mid_pfx_t;

	typedef struct packed {
		logic byte_op;
		logic use_carry;
		logic is_signed;
		mid_alu_t alu;
		mid_md_t muldiv;
		mid_bit_t bitop;
		mid_sh_t shift;
		logic step_en;
		logic step_dec;
		logic [1:0] step;
		logic ext_sign;
		logic ext_zero;
		mid_br_t branch;
		logic push;
		logic pop;
		logic normalize;
		mid_pfx_t prefix;
		logic prefix_reg;
	} mid_ctl_t;

endpackage

// ---- inc/mid_rst_if.sv ----
// Purpose: Link between decoder and reset sequencer
// Assumes: Single core clock
// Notes: start is a one-cycle pulse

`timescale 1ns/1ps

interface mid_rst_if;
	logic start;
	logic busy;

	modport ctl (output start, input busy);
	modport seq (input start, output busy);
endinterface

// ---- design/mid_reset_seq.sv ----
// Purpose: Internal reset sequence timer
// Assumes: start arrives as a one-cycle pulse
// Notes: busy stands for exactly RST_SEQ_CYCLES cycles

`timescale 1ns/1ps

module mid_reset_seq
	import mid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control link
	mid_rst_if.seq link
);

	logic [RST_CNT_W-1:0] cnt;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			link.busy <= 1'b0;
			cnt <= '0;
		end else if (!link.busy && link.start) begin
			link.busy <= 1'b1;
			cnt <= '0;
		end else if (link.busy) begin
			cnt <= cnt + 1'b1;
			if (cnt == RST_CNT_LAST) begin
				link.busy <= 1'b0;
			end
		end
	end

endmodule // mid_reset_seq

// ---- design/mid_decoder.sv ----
// Purpose: Instruction decoder between fetch and the execution datapath
// Assumes: Fetch holds instr stable while fetch_valid is high without fetch_ready
// Notes: Decode result appears one cycle after the instruction is taken
// Contract
// (RULE1) Add and subtract, word or byte, with or without carry; 2 or 4 bytes.
// (RULE2) Two-byte multiply of two named registers, signed or unsigned, 16 by 16.
// (RULE3) Two-byte divide of low multiply/divide register by named register.
// (RULE4) Two-byte long divide of 32-bit multiply/divide pair by named register.
// (RULE5) Complement and negate on a named register, word or byte, 2 bytes.
// (RULE6) AND, OR, XOR in word and byte widths, 2 or 4 bytes.
// (RULE7) Bit clear/set are 2 bytes; bit move, optionally inverted, is 4 bytes.
// (RULE8) Four-byte bit AND/OR/XOR and bit compare between two direct bits.
// (RULE9) Four-byte masked update of high or low byte with immediate data.
// (RULE10) Compare with register, then decrement it by 1 or 2.
// (RULE11) Compare with register, then increment it by 1 or 2.
// (RULE12) Two-byte normalize count of one register written to another.
// (RULE13) Two-byte shifts and rotates on a word register; arithmetic keeps sign.
// (RULE14) Byte to word moves with sign or zero extension.
// (RULE15) Four-byte bit branches; variants clear or set the tested bit.
// (RULE16) Four-byte call that pushes a named register then calls absolute.
// (RULE17) Four-byte context switch: push register then load it with operand.
// (RULE18) Distinct 2-byte returns: intra, inter segment, interrupt, and with pop.
// (RULE19) Two-byte trap entering a service routine by immediate number.
// (RULE20) Four-byte system requests: reset, idle, power down, watchdog, end of init.
// (RULE21) Power down only decoded as such while the NMI input is low.
// (RULE22) Atomic and extended register/page/segment prefixes, 2 or 4 bytes.
// (RULE23) Null operation changes nothing but the instruction pointer.
// (RULE24) Software reset starts a 512-cycle sequence driving the reset input pin low.
// (RULE25) Instruction length comes from the first opcode byte.

`timescale 1ns/1ps

module mid_decoder
	import mid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fetch side
	input wire logic fetch_valid,
	input wire logic [INSTR_W-1:0] fetch_instr,
	output logic fetch_ready,
	output logic [LEN_W-1:0] fetch_len_bytes,
	// Decode result
	output logic dec_valid,
	output mid_op_t dec_op,
	output logic [LEN_W-1:0] dec_len_bytes,
	output logic dec_illegal,
	output logic [REG_SEL_W-1:0] dec_reg_a,
	output logic [REG_SEL_W-1:0] dec_reg_b,
	output logic [IMM_W-1:0] dec_imm,
	output mid_ctl_t dec_ctl,
	// System requests
	output logic sw_reset_req,
	output logic idle_req,
	output logic power_down_op_req,
	output logic watchdog_service_req,
	output logic watchdog_disable_req,
	output logic reset_seq_active,
	// Pins
	input wire logic nmi_pin,
	output logic reset_output_pin,
	output logic reset_in_pin_out,
	output logic reset_in_pin_oe_b
);

	mid_rst_if rst_link ();

	logic nmi_meta;
	logic nmi_sync;
	logic take;
	logic [OPC_OP_W-1:0] op_field;
	logic in_range;
	logic var_bit;
	logic long_bit;
	mid_op_t next_op;
	mid_ctl_t next_ctl;
	logic next_long;
	logic [IMM_W-1:0] next_imm;

	function automatic logic is_long(mid_op_t op, logic long_form);
		unique case (op)
			OP_MULTIPLY, OP_DIVIDE, OP_LONG_DIVIDE, OP_COMPLEMENT, OP_NEGATE,
			OP_BIT_CLEAR, OP_BIT_SET, OP_NORMALIZE_COUNT, OP_SHIFT_LEFT,
			OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ARITH_SHIFT_RIGHT,
			OP_TRAP, OP_PUSH, OP_POP, OP_RETURN, OP_INTER_SEGMENT_RETURN,
			OP_RETURN_AND_POP, OP_INTERRUPT_RETURN, OP_ATOMIC, OP_EXTENDED_REGISTER,
			OP_NULL:
				return 1'b0;
			OP_BIT_MOVE, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_COMPARE,
			OP_MASKED_BYTE_FIELD, OP_JUMP, OP_BRANCH_ON_BIT, OP_BRANCH_AND_CLEAR_BIT,
			OP_BRANCH_AND_SET_BIT, OP_CALL, OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH,
			OP_SOFTWARE_RESET, OP_IDLE, OP_POWER_DOWN, OP_WATCHDOG_SERVICE,
			OP_WATCHDOG_DISABLE, OP_END_OF_INIT:
				return 1'b1;
			default:
				return long_form;
		endcase
	endfunction

	// NMI arrives from a pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			nmi_meta <= 1'b0;
			nmi_sync <= 1'b0;
		end else begin
			nmi_meta <= nmi_pin;
			nmi_sync <= nmi_meta;
		end
	end

	// No new instruction while the core sits in its reset sequence
	assign fetch_ready = !rst_link.busy;
	assign take = fetch_valid && fetch_ready;

	assign op_field = fetch_instr[OPC_OP_MSB:OPC_OP_LSB];
	assign in_range = (op_field <= OP_LAST_CODE);
	assign var_bit = fetch_instr[OPC_VAR_BIT];
	assign long_bit = fetch_instr[OPC_LONG_BIT];
	// Unknown codes decode as a null op so the pipeline keeps moving
	assign next_op = in_range ? mid_op_t'(op_field) : OP_NULL;
	assign next_long = is_long(next_op, long_bit);
	assign fetch_len_bytes = next_long ? BYTES_LONG : BYTES_SHORT; // RULE25
	assign next_imm = next_long ? fetch_instr[LONG_IMM_LSB +: IMM_W]
		: {{(IMM_W-SHORT_IMM_W){1'b0}}, fetch_instr[SHORT_IMM_LSB +: SHORT_IMM_W]};

	always_comb begin
		next_ctl = '0; // RULE23
		unique case (next_op)
			OP_ADD, OP_ADD_WITH_CARRY: begin
				next_ctl.alu = ALU_ADD; // RULE1
				next_ctl.byte_op = var_bit;
				next_ctl.use_carry = (next_op == OP_ADD_WITH_CARRY);
			end
			OP_SUB, OP_SUBTRACT_WITH_CARRY: begin
				next_ctl.alu = ALU_SUB; // RULE1
				next_ctl.byte_op = var_bit;
				next_ctl.use_carry = (next_op == OP_SUBTRACT_WITH_CARRY);
			end
			OP_MULTIPLY: begin
				next_ctl.muldiv = MD_MUL; // RULE2
				next_ctl.is_signed = !var_bit;
			end
			OP_DIVIDE: begin
				next_ctl.muldiv = MD_DIV_LOW; // RULE3
				next_ctl.is_signed = !var_bit;
			end
			OP_LONG_DIVIDE: begin
				next_ctl.muldiv = MD_DIV_PAIR; // RULE4
				next_ctl.is_signed = !var_bit;
			end
			OP_COMPLEMENT: begin
				next_ctl.alu = ALU_COMPLEMENT; // RULE5
				next_ctl.byte_op = var_bit;
			end
			OP_NEGATE: begin
				next_ctl.alu = ALU_NEGATE; // RULE5
				next_ctl.byte_op = var_bit;
			end
			OP_AND: begin
				next_ctl.alu = ALU_AND; // RULE6
				next_ctl.byte_op = var_bit;
			end
			OP_OR: begin
				next_ctl.alu = ALU_OR; // RULE6
				next_ctl.byte_op = var_bit;
			end
			OP_XOR: begin
				next_ctl.alu = ALU_XOR; // RULE6
				next_ctl.byte_op = var_bit;
			end
			OP_COMPARE: begin
				next_ctl.alu = ALU_CMP;
				next_ctl.byte_op = var_bit;
			end
			OP_BIT_CLEAR: next_ctl.bitop = BIT_CLEAR; // RULE7
			OP_BIT_SET: next_ctl.bitop = BIT_SET; // RULE7
			OP_BIT_MOVE: begin
				// Variant bit selects the inverted copy
				next_ctl.bitop = BIT_MOVE; // RULE7
				next_ctl.use_carry = 1'b0;
				next_ctl.is_signed = var_bit;
			end
			OP_BIT_AND: next_ctl.bitop = BIT_AND; // RULE8
			OP_BIT_OR: next_ctl.bitop = BIT_OR; // RULE8
			OP_BIT_XOR: next_ctl.bitop = BIT_XOR; // RULE8
			OP_BIT_COMPARE: next_ctl.bitop = BIT_COMPARE; // RULE8
			OP_MASKED_BYTE_FIELD: begin
				next_ctl.bitop = var_bit ? BIT_FIELD_HIGH : BIT_FIELD_LOW; // RULE9
			end
			OP_COMPARE_DECREMENT: begin
				next_ctl.alu = ALU_CMP; // RULE10
				next_ctl.step_en = 1'b1;
				next_ctl.step_dec = 1'b1;
				next_ctl.step = var_bit ? STEP_TWO : STEP_ONE;
			end
			OP_COMPARE_INCREMENT: begin
				next_ctl.alu = ALU_CMP; // RULE11
				next_ctl.step_en = 1'b1;
				next_ctl.step_dec = 1'b0;
				next_ctl.step = var_bit ? STEP_TWO : STEP_ONE;
			end
			OP_NORMALIZE_COUNT: next_ctl.normalize = 1'b1; // RULE12
			OP_SHIFT_LEFT: next_ctl.shift = SH_LEFT; // RULE13
			OP_SHIFT_RIGHT: next_ctl.shift = SH_RIGHT; // RULE13
			OP_ROTATE_LEFT: next_ctl.shift = SH_ROL; // RULE13
			OP_ROTATE_RIGHT: next_ctl.shift = SH_ROR; // RULE13
			OP_ARITH_SHIFT_RIGHT: begin
				next_ctl.shift = SH_ARITH_SHIFT_RIGHT_OP; // RULE13
				next_ctl.is_signed = 1'b1;
			end
			OP_MOVE: begin
				next_ctl.alu = ALU_MOVE;
				next_ctl.byte_op = var_bit;
			end
			OP_BYTE_SIGN_EXTEND_MOVE: begin
				next_ctl.alu = ALU_MOVE; // RULE14
				next_ctl.ext_sign = 1'b1;
			end
			OP_BYTE_ZERO_EXTEND_MOVE: begin
				next_ctl.alu = ALU_MOVE; // RULE14
				next_ctl.ext_zero = 1'b1;
			end
			OP_JUMP: next_ctl.branch = BR_JUMP;
			OP_BRANCH_ON_BIT: begin
				next_ctl.branch = var_bit ? BR_IF_CLEAR : BR_IF_SET; // RULE15
			end
			OP_BRANCH_AND_CLEAR_BIT: next_ctl.branch = BR_SET_THEN_CLEAR; // RULE15
			OP_BRANCH_AND_SET_BIT: next_ctl.branch = BR_CLEAR_THEN_SET; // RULE15
			OP_CALL: next_ctl.branch = BR_CALL;
			OP_PUSH_AND_CALL: begin
				next_ctl.push = 1'b1; // RULE16
				next_ctl.branch = BR_CALL;
			end
			OP_TRAP: next_ctl.branch = BR_TRAP; // RULE19
			OP_PUSH: next_ctl.push = 1'b1;
			OP_POP: next_ctl.pop = 1'b1;
			OP_CONTEXT_SWITCH: begin
				next_ctl.push = 1'b1; // RULE17
				next_ctl.alu = ALU_MOVE;
			end
			OP_RETURN: next_ctl.branch = BR_RET; // RULE18
			OP_INTER_SEGMENT_RETURN: next_ctl.branch = BR_RET_SEG; // RULE18
			OP_RETURN_AND_POP: begin
				next_ctl.branch = BR_RET; // RULE18
				next_ctl.pop = 1'b1;
			end
			OP_INTERRUPT_RETURN: next_ctl.branch = BR_RET_INT; // RULE18
			OP_ATOMIC: next_ctl.prefix = PFX_ATOMIC; // RULE22
			OP_EXTENDED_REGISTER: next_ctl.prefix = PFX_REG; // RULE22
			OP_EXTENDED_PAGE: begin
				next_ctl.prefix = PFX_PAGE; // RULE22
				next_ctl.prefix_reg = var_bit;
			end
			OP_EXTENDED_SEGMENT: begin
				next_ctl.prefix = PFX_SEGMENT; // RULE22
				next_ctl.prefix_reg = var_bit;
			end
			// Null op and system ops leave the control word clear
			OP_NULL, OP_SOFTWARE_RESET, OP_IDLE, OP_POWER_DOWN, OP_WATCHDOG_SERVICE,
			OP_WATCHDOG_DISABLE, OP_END_OF_INIT: next_ctl = '0;
			default: next_ctl = '0;
		endcase
	end

	// Decode result
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= take;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dec_op <= OP_NULL;
			dec_len_bytes <= BYTES_SHORT;
			dec_illegal <= 1'b0;
			dec_reg_a <= '0;
			dec_reg_b <= '0;
			dec_imm <= '0;
			dec_ctl <= '0;
		end else if (take) begin
			dec_op <= next_op;
			dec_len_bytes <= fetch_len_bytes;
			dec_illegal <= !in_range;
			dec_reg_a <= fetch_instr[REGA_LSB +: REG_SEL_W]; // RULE2
			dec_reg_b <= fetch_instr[REGB_LSB +: REG_SEL_W];
			dec_imm <= next_imm; // RULE19
			dec_ctl <= next_ctl;
		end
	end

	// System-control pulses
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_reset_req <= 1'b0;
			idle_req <= 1'b0;
			power_down_op_req <= 1'b0;
			watchdog_service_req <= 1'b0;
			watchdog_disable_req <= 1'b0;
		end else begin
			sw_reset_req <= take && (next_op == OP_SOFTWARE_RESET); // RULE20
			idle_req <= take && (next_op == OP_IDLE); // RULE20
			// With NMI high execution simply continues
			power_down_op_req <= take && (next_op == OP_POWER_DOWN) && !nmi_sync; // RULE21
			watchdog_service_req <= take && (next_op == OP_WATCHDOG_SERVICE); // RULE20
			watchdog_disable_req <= take && (next_op == OP_WATCHDOG_DISABLE); // RULE20
		end
	end

	// End of init stays signalled until the next reset sequence
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reset_output_pin <= 1'b0;
		end else if (rst_link.busy) begin
			reset_output_pin <= 1'b0;
		end else if (take && (next_op == OP_END_OF_INIT)) begin
			reset_output_pin <= 1'b1; // RULE20
		end
	end

	assign rst_link.start = sw_reset_req; // RULE24

	mid_reset_seq u_reset_seq (
		.clk(clk),
		.rst_b(rst_b),
		.link(rst_link.seq)
	);

	// Pin pulled low, open-drain style, for the whole sequence
	assign reset_in_pin_out = 1'b0; // RULE24
	assign reset_in_pin_oe_b = !rst_link.busy; // RULE24
	assign reset_seq_active = rst_link.busy;

endmodule // mid_decoder

// ---- dv/mid_decoder_checker.sv ----
// Purpose: Port-level assertions for the instruction decoder
// Assumes: Sees only the mid_decoder ports
// Notes: Bound to every mid_decoder instance below
`timescale 1ns/1ps
module mid_decoder_checker
	import mid_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Fetch side
	input wire logic fetch_valid,
	input wire logic [INSTR_W-1:0] fetch_instr,
	input wire logic fetch_ready,
	input wire logic [LEN_W-1:0] fetch_len_bytes,
	// Decode result
	input wire logic dec_valid,
	input wire mid_op_t dec_op,
	input wire logic [LEN_W-1:0] dec_len_bytes,
	input wire logic dec_illegal,
	input wire logic [REG_SEL_W-1:0] dec_reg_a,
	input wire logic [REG_SEL_W-1:0] dec_reg_b,
	input wire logic [IMM_W-1:0] dec_imm,
	// Requests and pins
	input wire logic sw_reset_req,
	input wire logic idle_req,
	input wire logic power_down_op_req,
	input wire logic reset_seq_active,
	input wire logic reset_output_pin,
	input wire logic reset_in_pin_oe_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic take;
	logic [OPC_OP_W-1:0] opi;
	logic [RST_CNT_W:0] seq_cnt;
	assign take = fetch_valid && fetch_ready;
	assign opi = fetch_instr[OPC_OP_MSB:OPC_OP_LSB];
	// Cleared by reset, so an aborted sequence is never judged
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_cnt <= '0;
		end else begin
			seq_cnt <= reset_seq_active ? seq_cnt + 1'b1 : '0;
		end
	end
	property p_take; take |=> dec_valid; endproperty
	a_take: assert property (p_take) else $error("no result after a take");
	property p_quiet; !take |=> !dec_valid; endproperty
	a_quiet: assert property (p_quiet) else $error("result without a take");
	property p_len; take |=> dec_len_bytes == $past(fetch_len_bytes); endproperty
	a_len: assert property (p_len) else $error("length differs from fetch length");
	property p_regs;
		take |=> dec_reg_a == $past(fetch_instr[15:12]) && dec_reg_b == $past(fetch_instr[11:8]);
	endproperty
	a_regs: assert property (p_regs) else $error("register selects wrong");
	property p_illegal;
		take && opi > OP_LAST_CODE |=> dec_illegal && dec_op == OP_NULL && dec_len_bytes == BYTES_SHORT;
	endproperty
	a_illegal: assert property (p_illegal) else $error("unknown opcode not flagged");
	property p_software_reset_op;
		take && opi == OP_SOFTWARE_RESET |=> sw_reset_req ##1 reset_seq_active;
	endproperty
	a_software_reset_op: assert property (p_software_reset_op) else $error("software reset not started");
	property p_ready;
		fetch_ready != reset_seq_active && reset_seq_active != reset_in_pin_oe_b;
	endproperty
	a_ready: assert property (p_ready) else $error("ready or pin enable wrong");
	property p_seq_len;
		$fell(reset_seq_active) && $past(rst_b) |-> seq_cnt == RST_SEQ_CYCLES;
	endproperty
	a_seq_len: assert property (p_seq_len) else $error("reset sequence length wrong");
	property p_seq_max; reset_seq_active |-> seq_cnt < RST_SEQ_CYCLES; endproperty
	a_seq_max: assert property (p_seq_max) else $error("reset sequence too long");
	property p_hold;
		!take |=> $stable(dec_op) && $stable(dec_imm) && $stable(dec_len_bytes);
	endproperty
	a_hold: assert property (p_hold) else $error("result changed without a take");
	property p_idle; take && opi == OP_IDLE |=> idle_req && !power_down_op_req && !sw_reset_req; endproperty
	a_idle: assert property (p_idle) else $error("idle request wrong");
	property p_eoi; take && opi == OP_END_OF_INIT |=> ##[0:1] reset_output_pin; endproperty
	a_eoi: assert property (p_eoi) else $error("end of init not shown on pin");
	c_software_reset_op: cover property (take && opi == OP_SOFTWARE_RESET);
	c_power_down_op: cover property (power_down_op_req);
	c_illegal: cover property (dec_valid && dec_illegal);
endmodule // mid_decoder_checker

bind mid_decoder mid_decoder_checker i_mid_decoder_checker (
	.clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid), .fetch_instr(fetch_instr),
	.fetch_ready(fetch_ready), .fetch_len_bytes(fetch_len_bytes), .dec_valid(dec_valid),
	.dec_op(dec_op), .dec_len_bytes(dec_len_bytes), .dec_illegal(dec_illegal),
	.dec_reg_a(dec_reg_a), .dec_reg_b(dec_reg_b), .dec_imm(dec_imm),
	.sw_reset_req(sw_reset_req), .idle_req(idle_req), .power_down_op_req(power_down_op_req),
	.reset_seq_active(reset_seq_active), .reset_output_pin(reset_output_pin),
	.reset_in_pin_oe_b(reset_in_pin_oe_b)
);

// ---- dv/mid_fetch_model.sv ----
// Purpose: Fetch stage model offering instructions to the decoder
// Assumes: fetch_ready only changes after a rising edge
// Notes: Drives on the falling edge
`timescale 1ns/1ps
module mid_fetch_model
	import mid_pkg::*;
(
	// Clock
	input wire logic clk,
	// Fetch handshake
	input wire logic fetch_ready,
	output logic fetch_valid,
	output logic [INSTR_W-1:0] fetch_instr
);
	initial begin
		fetch_valid = 1'b0;
		fetch_instr = '0;
	end
	// Offer stands through any stall, up to the taking edge
	task automatic offer(input logic [INSTR_W-1:0] w);
		@(negedge clk);
		fetch_valid = 1'b1;
		fetch_instr = w;
		while (fetch_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
	endtask
	// Released bus shows the inverse, never a stale word
	task automatic rest();
		@(negedge clk);
		fetch_valid = 1'b0;
		fetch_instr = ~fetch_instr;
	endtask
endmodule // mid_fetch_model

// ---- dv/mid_decoder_bench.sv ----
// Purpose: Self-checking bench for the instruction decoder
// Assumes: One decode result per take, one cycle later
// Notes: Expected results queued at each take, checked at each result
`timescale 1ns/1ps
module mid_decoder_bench
	import mid_pkg::*;
();
	logic clk, rst_b, nmi_pin, fetch_valid, fetch_ready, dec_valid, dec_illegal;
	logic [INSTR_W-1:0] fetch_instr, w;
	logic [LEN_W-1:0] fetch_len_bytes, dec_len_bytes;
	logic [REG_SEL_W-1:0] dec_reg_a, dec_reg_b;
	logic [IMM_W-1:0] dec_imm;
	mid_op_t dec_op;
	mid_ctl_t dec_ctl;
	logic sw_reset_req, idle_req, power_down_op_req, watchdog_service_req, watchdog_disable_req;
	logic reset_seq_active, reset_output_pin, reset_in_pin_out, reset_in_pin_oe_b;
	logic [INSTR_W:0] exp_q[$];
	int miscompares, n_compared, cycles, k, m;

	mid_decoder i_mid_decoder (.clk(clk), .rst_b(rst_b), .fetch_valid(fetch_valid),
		.fetch_instr(fetch_instr), .fetch_ready(fetch_ready), .fetch_len_bytes(fetch_len_bytes),
		.dec_valid(dec_valid), .dec_op(dec_op), .dec_len_bytes(dec_len_bytes),
		.dec_illegal(dec_illegal), .dec_reg_a(dec_reg_a), .dec_reg_b(dec_reg_b),
		.dec_imm(dec_imm), .dec_ctl(dec_ctl), .sw_reset_req(sw_reset_req), .idle_req(idle_req),
		.power_down_op_req(power_down_op_req), .watchdog_service_req(watchdog_service_req),
		.watchdog_disable_req(watchdog_disable_req), .reset_seq_active(reset_seq_active),
		.nmi_pin(nmi_pin), .reset_output_pin(reset_output_pin),
		.reset_in_pin_out(reset_in_pin_out), .reset_in_pin_oe_b(reset_in_pin_oe_b));
	mid_fetch_model i_mid_fetch_model (.clk(clk), .fetch_ready(fetch_ready),
		.fetch_valid(fetch_valid), .fetch_instr(fetch_instr));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic conclude();
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask

	task automatic go(input logic [INSTR_W-1:0] v);
		i_mid_fetch_model.offer(v);
		exp_q.push_back({nmi_pin, v});
	endtask

	function automatic logic [LEN_W-1:0] len_of(input logic [7:0] b);
		if (b[7:2] > OP_LAST_CODE) return BYTES_SHORT;
		case (mid_op_t'(b[7:2]))
			OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUBTRACT_WITH_CARRY, OP_AND, OP_OR, OP_XOR,
			OP_COMPARE, OP_COMPARE_DECREMENT, OP_COMPARE_INCREMENT, OP_MOVE,
			OP_BYTE_SIGN_EXTEND_MOVE, OP_BYTE_ZERO_EXTEND_MOVE, OP_EXTENDED_PAGE,
			OP_EXTENDED_SEGMENT: return b[0] ? BYTES_LONG : BYTES_SHORT;
			OP_BIT_MOVE, OP_BIT_AND, OP_BIT_OR, OP_BIT_XOR, OP_BIT_COMPARE, OP_MASKED_BYTE_FIELD,
			OP_JUMP, OP_BRANCH_ON_BIT, OP_BRANCH_AND_CLEAR_BIT, OP_BRANCH_AND_SET_BIT, OP_CALL,
			OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH, OP_SOFTWARE_RESET, OP_IDLE, OP_POWER_DOWN,
			OP_WATCHDOG_SERVICE, OP_WATCHDOG_DISABLE, OP_END_OF_INIT: return BYTES_LONG;
			default: return BYTES_SHORT;
		endcase
	endfunction

	task automatic check(input logic [INSTR_W:0] e);
		mid_op_t o;
		logic [LEN_W-1:0] n;
		o = e[7:2] > OP_LAST_CODE ? OP_NULL : mid_op_t'(e[7:2]);
		n = len_of(e[7:0]);
		cmp(dec_op, o);
		cmp(dec_illegal, e[7:2] > OP_LAST_CODE);
		cmp(dec_len_bytes, n);
		cmp(dec_imm, n == BYTES_LONG ? e[31:16] : {8'h00, e[15:8]});
		cmp({dec_reg_a, dec_reg_b}, e[15:8]);
		cmp(sw_reset_req, o == OP_SOFTWARE_RESET);
		cmp(idle_req, o == OP_IDLE);
		cmp(power_down_op_req, o == OP_POWER_DOWN && !e[INSTR_W]);
		cmp(watchdog_service_req, o == OP_WATCHDOG_SERVICE);
		cmp(watchdog_disable_req, o == OP_WATCHDOG_DISABLE);
		case (o)
			OP_MULTIPLY, OP_DIVIDE, OP_LONG_DIVIDE: begin
				cmp(dec_ctl.muldiv, o - OP_MULTIPLY + 1);
				cmp(dec_ctl.is_signed, !e[OPC_VAR_BIT]);
			end
			OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
			OP_ARITH_SHIFT_RIGHT: cmp(dec_ctl.shift, o - OP_SHIFT_LEFT + 1);
			OP_COMPARE_DECREMENT, OP_COMPARE_INCREMENT: begin
				cmp(dec_ctl.step, e[OPC_VAR_BIT] ? STEP_TWO : STEP_ONE);
				cmp(dec_ctl.step_dec, o == OP_COMPARE_DECREMENT);
			end
			OP_BYTE_SIGN_EXTEND_MOVE, OP_BYTE_ZERO_EXTEND_MOVE: begin
				cmp({dec_ctl.ext_sign, dec_ctl.ext_zero}, o[0] ? 2'h2 : 2'h1);
			end
			OP_BIT_CLEAR, OP_BIT_SET: cmp(dec_ctl.bitop, o - OP_BIT_CLEAR + 1);
			OP_MASKED_BYTE_FIELD: begin
				cmp(dec_ctl.bitop, e[OPC_VAR_BIT] ? BIT_FIELD_HIGH : BIT_FIELD_LOW);
			end
			OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_CARRY: cmp(dec_ctl.use_carry, 1'b1);
			OP_COMPLEMENT, OP_NEGATE: cmp(dec_ctl.byte_op, e[OPC_VAR_BIT]);
			OP_NORMALIZE_COUNT: cmp(dec_ctl.normalize, 1'b1);
			OP_BRANCH_ON_BIT: cmp(dec_ctl.branch, e[OPC_VAR_BIT] ? BR_IF_CLEAR : BR_IF_SET);
			OP_PUSH_AND_CALL, OP_CONTEXT_SWITCH: cmp(dec_ctl.push, 1'b1);
			OP_RETURN_AND_POP: cmp({dec_ctl.branch, dec_ctl.pop}, {BR_RET, 1'b1});
			OP_TRAP: cmp(dec_ctl.branch, BR_TRAP);
			OP_NULL, OP_SOFTWARE_RESET, OP_IDLE, OP_POWER_DOWN, OP_WATCHDOG_SERVICE,
			OP_WATCHDOG_DISABLE, OP_END_OF_INIT: cmp(|dec_ctl, 1'b0);
			default: ;
		endcase
	endtask

	always @(negedge clk) begin
		if (rst_b === 1'b1 && dec_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp(1'b1, 1'b0);
			end else begin
				check(exp_q.pop_front());
			end
		end
	end

	// Whole run needs about 3100 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		rst_b = 1'b0;
		nmi_pin = 1'b0;
		void'($urandom(7839));
		repeat (5) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		// Every opcode index and variant, about half back to back; stalls while sequencing
		for (int p = 0; p < 4; p++) begin
			for (int i = 0; i < 64; i++) begin
				w = $urandom;
				w[7:0] = {i[5:0], p[1:0]};
				go(w);
				if (w[31]) i_mid_fetch_model.rest();
			end
		end
		go({24'h0, OP_END_OF_INIT, 2'h0});
		i_mid_fetch_model.rest();
		repeat (2) @(negedge clk);
		cmp(reset_output_pin, 1'b1);
		go({24'h0, OP_SOFTWARE_RESET, 2'h0});
		i_mid_fetch_model.rest();
		k = 0;
		m = 0;
		for (int t = 0; t < 600; t++) begin
			@(negedge clk);
			k += (fetch_ready === 1'b0);
			m += (reset_in_pin_oe_b === 1'b0);
		end
		cmp(k, RST_SEQ_CYCLES);
		cmp(m, RST_SEQ_CYCLES);
		cmp({reset_output_pin, reset_in_pin_out}, 2'h0);
		// Power down refused while the interrupt pin is high
		nmi_pin = 1'b1;
		repeat (4) @(negedge clk);
		go({24'h0, OP_POWER_DOWN, 2'h1});
		i_mid_fetch_model.rest();
		nmi_pin = 1'b0;
		repeat (4) @(negedge clk);
		go({24'h0, OP_POWER_DOWN, 2'h0});
		// Reset lands in the middle of a software reset sequence
		go({24'h0, OP_SOFTWARE_RESET, 2'h0});
		i_mid_fetch_model.rest();
		repeat (5) @(negedge clk);
		rst_b = 1'b0;
		@(negedge clk);
		cmp({dec_valid, fetch_ready, reset_in_pin_oe_b, reset_output_pin}, 4'h6);
		cmp({dec_op, dec_len_bytes}, {OP_NULL, BYTES_SHORT});
		rst_b = 1'b1;
		go({16'hA5C3, 8'h7E, OP_MULTIPLY, 2'h2});
		i_mid_fetch_model.rest();
		repeat (3) @(negedge clk);
		cmp(exp_q.size(), 0);
		conclude();
	end
endmodule // mid_decoder_bench
